// File: design/mradc_pkg.sv
// constants, types and register map of the multirange converter access block
package mradc_pkg;

  // -----------------------------------------------------------------
  // bus widths and responses
  // -----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 32;         // axi address width
  localparam int unsigned DATA_W      = 32;         // axi data width
  localparam int unsigned STRB_W      = 4;          // byte enables
  localparam logic [1:0]  RESP_OKAY   = 2'h0;       // normal answer
  localparam logic [1:0]  RESP_SLVERR = 2'h2;       // refused or unmapped

  // -----------------------------------------------------------------
  // register indices as printed; byte address is four times the index
  // -----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] IDX_STATUS   = 32'h1080_0000;
  localparam logic [ADDR_W-1:0] IDX_CONTROL  = 32'h10F0_0000;
  localparam logic [ADDR_W-1:0] IDX_RES_LOW  = 32'h10F0_0000;
  localparam logic [ADDR_W-1:0] IDX_RES_HIGH = 32'h10F0_0001;
  localparam logic [ADDR_W-1:0] IDX_OPTION   = 32'h2240_0000;

  localparam logic [ADDR_W-1:0] ADDR_STATUS   = {IDX_STATUS[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CONTROL  = {IDX_CONTROL[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_RES_LOW  = {IDX_RES_LOW[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_RES_HIGH = {IDX_RES_HIGH[ADDR_W-3:0], 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_OPTION   = {IDX_OPTION[ADDR_W-3:0], 2'h0};

  // -----------------------------------------------------------------
  // field positions and widths
  // -----------------------------------------------------------------
  localparam int unsigned STAT_BUSY_BIT    = 7;     // one while converting
  localparam int unsigned STAT_TIMEOUT_BIT = 6;     // last conversion timed out
  localparam int unsigned OPT_FITTED_BIT   = 0;     // option present
  localparam int unsigned BYTE_W           = 8;     // one register byte
  localparam int unsigned RAW_W            = 12;    // converter word
  localparam int unsigned RESULT_W         = 16;    // formatted result
  localparam int unsigned SIGN_BIT         = 11;    // sign of bipolar word

  // control byte layout, bit 7 down to bit 0
  typedef struct packed {
    logic [2:0] mode;                               // bits 7..5
    logic       range10;                            // bit 4
    logic       bipolar;                            // bit 3
    logic [2:0] channel;                            // bits 2..0
  } mradc_ctrl_t;

  // request to the converter chip
  typedef struct packed {
    logic        start;                             // one-cycle start pulse
    mradc_ctrl_t ctrl;                              // latched control byte
  } mradc_conv_req_t;

  // answer from the converter chip
  typedef struct packed {
    logic             done;                         // one-cycle completion
    logic [RAW_W-1:0] data;                         // raw conversion word
  } mradc_conv_rsp_t;

  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic [BYTE_W-1:0]   CTRL_RESET   = 8'h40;   // ch0, uni, 5 V
  localparam logic [RESULT_W-1:0] RESULT_RESET = 16'h0000;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int unsigned CONV_TIME_NS  = 12000;    // longest conversion
  localparam int unsigned CLK_PERIOD_NS = 25;       // 40 MHz clock
  localparam int unsigned CONV_CYCLES_RAW = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned CONV_CYCLES   = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
  localparam int unsigned CNT_W         = 9;        // holds CONV_CYCLES
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ONE   = 9'h001;

  // conversion sequencer states
  typedef enum logic [2:0] {
    CV_IDLE  = 3'h1,                                // waiting for a start
    CV_START = 3'h2,                                // start pulse out
    CV_WAIT  = 3'h4                                 // waiting for done
  } mradc_conv_state_t;

endpackage

// File: design/mradc_result_fmt.sv
// result register that formats the raw converter word as binary or two's complement
`timescale 1ns/1ps
module mradc_result_fmt (
  // clock and reset
  input  wire logic                              clock_i,
  input  wire logic                              reset_i,
  // raw word in
  input  wire logic                              load_i,
  input  wire logic                              bipolar_i,
  input  wire logic [mradc_pkg::RAW_W-1:0]       raw_i,
  // formatted result out
  output logic      [mradc_pkg::RESULT_W-1:0]    result_o
);
  import mradc_pkg::*;

  logic [RESULT_W-1:0] result_reg;                  // held result
  logic [RESULT_W-1:0] result_next;                 // formatted word

  // -----------------------------------------------------------------
  // per-bit formatting
  // -----------------------------------------------------------------
  // low bits copy the raw word; upper bits are zero or the sign copy
  for (genvar i = 0; i < RESULT_W; i++) begin : g_bit
    if (i < RAW_W) begin : g_raw
      assign result_next[i] = raw_i[i];
    end else begin : g_ext
      assign result_next[i] = bipolar_i & raw_i[SIGN_BIT];
    end
  end

  // -----------------------------------------------------------------
  // result register
  // -----------------------------------------------------------------
  // the mode used is the one latched with the start, not a later one
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      result_reg <= RESULT_RESET;
    end else if (load_i) begin
      result_reg <= result_next;
    end
  end

  assign result_o = result_reg;

endmodule

// File: design/mradc_access.sv
// axi4-lite access logic for the optional eight-channel 12-bit converter
`timescale 1ns/1ps
module mradc_access (
  // clock and reset
  input  wire logic                            clock_i,
  input  wire logic                            reset_i,
  // axi4-lite write address channel
  input  wire logic [mradc_pkg::ADDR_W-1:0]    s_axi_awaddr_i,
  input  wire logic                            s_axi_awvalid_i,
  output logic                                 s_axi_awready_o,
  // axi4-lite write data channel
  input  wire logic [mradc_pkg::DATA_W-1:0]    s_axi_wdata_i,
  input  wire logic [mradc_pkg::STRB_W-1:0]    s_axi_wstrb_i,
  input  wire logic                            s_axi_wvalid_i,
  output logic                                 s_axi_wready_o,
  // axi4-lite write response channel
  output logic      [1:0]                      s_axi_bresp_o,
  output logic                                 s_axi_bvalid_o,
  input  wire logic                            s_axi_bready_i,
  // axi4-lite read address channel
  input  wire logic [mradc_pkg::ADDR_W-1:0]    s_axi_araddr_i,
  input  wire logic                            s_axi_arvalid_i,
  output logic                                 s_axi_arready_o,
  // axi4-lite read data channel
  output logic      [mradc_pkg::DATA_W-1:0]    s_axi_rdata_o,
  output logic      [1:0]                      s_axi_rresp_o,
  output logic                                 s_axi_rvalid_o,
  input  wire logic                            s_axi_rready_i,
  // converter chip
  output mradc_pkg::mradc_conv_req_t           conv_req_o,
  input  mradc_pkg::mradc_conv_rsp_t           conv_rsp_i,
  // board strap
  input  wire logic                            option_fitted_i
);
  import mradc_pkg::*;

  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  // write side holding registers
  logic                 aw_held_reg;                // write address taken
  logic [ADDR_W-1:0]    aw_addr_reg;                // taken write address
  logic                 w_held_reg;                 // write data taken
  logic [DATA_W-1:0]    w_data_reg;                 // taken write data
  logic [STRB_W-1:0]    w_strb_reg;                 // taken byte enables
  logic                 bvalid_reg;                 // response pending
  logic [1:0]           bresp_reg;                  // response code
  logic                 write_fire;                 // both halves present
  logic [1:0]           bresp_next;                 // decoded response
  logic                 start_req;                  // valid start write

  // read side registers
  logic                 rvalid_reg;                 // read data pending
  logic [DATA_W-1:0]    rdata_reg;                  // read data
  logic [1:0]           rresp_reg;                  // read response
  logic                 read_fire;                  // read address taken
  logic [DATA_W-1:0]    rdata_next;                 // decoded read data
  logic [1:0]           rresp_next;                 // decoded read response

  // conversion sequencer
  mradc_conv_state_t    state_reg;                  // sequencer state
  mradc_conv_state_t    state_next;                 // next state
  mradc_ctrl_t          ctrl_reg;                   // latched control byte
  logic                 start_reg;                  // start pulse to chip
  logic [CNT_W-1:0]     count_reg;                  // cycles spent waiting
  logic                 timeout_reg;                // last one timed out
  logic                 busy;                       // conversion under way
  logic                 done_seen;                  // chip answered in time
  logic                 time_up;                    // time bound reached

  // result and strap
  logic [RESULT_W-1:0]  result;                     // formatted result
  logic                 option_reg;                 // sampled option strap

  // -----------------------------------------------------------------
  // write address and data channels
  // -----------------------------------------------------------------
  // each half is taken on its own and parked; no new half is taken
  // while the previous write is still waiting for its response
  assign s_axi_awready_o = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready_o  = !w_held_reg && !bvalid_reg;
  assign write_fire      = aw_held_reg && w_held_reg && !bvalid_reg;

  // park the address half
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr_i;
    end else if (write_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  // park the data half
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata_i;
      w_strb_reg <= s_axi_wstrb_i;
    end else if (write_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // write decode
  // -----------------------------------------------------------------
  // only the control location is writable; the other mapped locations
  // are read-only and, like unmapped ones, answer with an error
  always_comb begin
    bresp_next = RESP_SLVERR;
    start_req  = 1'b0;
    if (aw_addr_reg == ADDR_CONTROL) begin
      bresp_next = RESP_OKAY;
      // the control byte sits in lane 0; a write that misses it is void
      start_req  = w_strb_reg[0] && !busy;
    end
  end

  // -----------------------------------------------------------------
  // write response channel
  // -----------------------------------------------------------------
  // response is held until the master takes it
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (write_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= bresp_next;
    end else if (s_axi_bready_i) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o  = bresp_reg;

  // -----------------------------------------------------------------
  // read decode
  // -----------------------------------------------------------------
  // the base location serves both the byte and the word read: lane 0
  // holds the low byte and lane 1 the high byte
  always_comb begin
    rdata_next = '0;
    rresp_next = RESP_OKAY;
    if (s_axi_araddr_i == ADDR_RES_LOW) begin
      rdata_next[RESULT_W-1:0] = result;
    end else if (s_axi_araddr_i == ADDR_RES_HIGH) begin
      rdata_next[BYTE_W-1:0] = result[RESULT_W-1:BYTE_W];
    end else if (s_axi_araddr_i == ADDR_STATUS) begin
      rdata_next[STAT_BUSY_BIT]    = busy;
      rdata_next[STAT_TIMEOUT_BIT] = timeout_reg;
    end else if (s_axi_araddr_i == ADDR_OPTION) begin
      rdata_next[OPT_FITTED_BIT] = option_reg;
    end else begin
      // unmapped: zero data and an error
      rresp_next = RESP_SLVERR;
    end
  end

  // -----------------------------------------------------------------
  // read address and data channels
  // -----------------------------------------------------------------
  // one read at a time: the address is refused while data wait
  assign s_axi_arready_o = !rvalid_reg;
  assign read_fire       = s_axi_arvalid_i && !rvalid_reg;

  // capture the answer on the address handshake and hold it
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OKAY;
    end else if (read_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rresp_next;
    end else if (s_axi_rready_i) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o  = rdata_reg;
  assign s_axi_rresp_o  = rresp_reg;

  // -----------------------------------------------------------------
  // conversion sequencer
  // -----------------------------------------------------------------
  assign busy      = (state_reg != CV_IDLE);
  assign done_seen = (state_reg == CV_WAIT) && conv_rsp_i.done;
  assign time_up   = (state_reg == CV_WAIT) && (count_reg == CONV_LAST);

  // next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CV_IDLE: begin
        // a start write while idle begins a conversion
        if (write_fire && start_req) begin
          state_next = CV_START;
        end
      end
      CV_START: begin
        state_next = CV_WAIT;
      end
      CV_WAIT: begin
        // the chip's answer ends the wait; the bound ends a hung chip
        if (done_seen || time_up) begin
          state_next = CV_IDLE;
        end
      end
      default: begin
        state_next = CV_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= CV_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // latch the control byte; the mode bits pass through untouched so
  // a host that writes other values gets what it asked for
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_reg <= CTRL_RESET;
    end else if (write_fire && start_req) begin
      ctrl_reg <= w_data_reg[BYTE_W-1:0];
    end
  end

  // one-cycle start pulse, raised for the single start state
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      start_reg <= 1'b0;
    end else begin
      start_reg <= (state_next == CV_START);
    end
  end

  // wait counter, cleared at each start
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      count_reg <= '0;
    end else if (state_reg != CV_WAIT) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + CNT_ONE;
    end
  end

  // timeout flag: cleared by the next start, set when the bound ends
  // the wait; both cannot meet in one cycle since start needs idle
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      timeout_reg <= 1'b0;
    end else if (time_up && !done_seen) begin
      timeout_reg <= 1'b1;
    end else if (write_fire && start_req) begin
      timeout_reg <= 1'b0;
    end
  end

  // drive the chip; one assignment keeps the struct port single-driven
  assign conv_req_o = '{start: start_reg,
                        ctrl:  ctrl_reg};

  // -----------------------------------------------------------------
  // result formatting
  // -----------------------------------------------------------------
  // a timed-out conversion leaves the previous result in place
  mradc_result_fmt u_result (
    .clock_i   (clock_i),
    .reset_i   (reset_i),
    .load_i    (done_seen),
    .bipolar_i (ctrl_reg.bipolar),
    .raw_i     (conv_rsp_i.data),
    .result_o  (result)
  );

  // -----------------------------------------------------------------
  // option strap
  // -----------------------------------------------------------------
  // sampled on every clock, never loaded from the pin under reset
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      option_reg <= 1'b0;
    end else begin
      option_reg <= option_fitted_i;
    end
  end

endmodule

// File: verification/mradc_conv_model.sv
// behavioural model of the converter chip behind the access block
`timescale 1ns/1ps
module mradc_conv_model (
  // clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  reset_i,
  // link to the access block
  input  mradc_pkg::mradc_conv_req_t req_i,
  output mradc_pkg::mradc_conv_rsp_t rsp_o,
  // bench controls: delay 0 means the chip never answers
  input  wire logic [9:0]            delay_i,
  input  wire logic [11:0]           sample_i,
  output logic      [7:0]            ctrl_o,
  output logic      [7:0]            starts_o
);
  import mradc_pkg::*;
  logic [9:0]  cnt_reg;  // cycles left until done
  logic [11:0] junk_reg; // data bus outside done changes every cycle
  // start latches the control byte and arms the countdown
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_reg  <= 10'h000;
      junk_reg <= 12'h000;
      ctrl_o   <= 8'h00;
      starts_o <= 8'h00;
    end else begin
      junk_reg <= junk_reg + 12'h5A7;
      if (req_i.start) begin
        cnt_reg  <= delay_i;
        ctrl_o   <= req_i.ctrl;
        starts_o <= starts_o + 8'h01;
      end else if (cnt_reg != 10'h000) begin
        cnt_reg <= cnt_reg - 10'h001;
      end
    end
  end
  // one-cycle done, data valid only alongside it
  assign rsp_o = {cnt_reg == 10'h001, (cnt_reg == 10'h001) ? sample_i : junk_reg};
endmodule

// File: verification/mradc_access_monitor.sv
// port checker for the multirange converter access block
`timescale 1ns/1ps
module mradc_access_monitor
  import mradc_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        reset_i,
  input wire logic [31:0] s_axi_awaddr_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input mradc_pkg::mradc_conv_req_t conv_req_o,
  input wire logic        option_fitted_i
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  logic wr_go; // both write halves taken together
  logic rd_go; // read address taken
  logic [31:0] ra; // read address shorthand
  assign wr_go = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  assign rd_go = s_axi_arvalid_i && s_axi_arready_o;
  assign ra = s_axi_araddr_i;
  chk_start_pulse:
    assert property (conv_req_o.start |=> !conv_req_o.start [*2]) else $error("long start");
  chk_start_with_b:
    assert property ($rose(conv_req_o.start) |-> s_axi_bvalid_o && s_axi_bresp_o == RESP_OKAY)
    else $error("start without write");
  chk_ctrl_hold:
    assert property (!conv_req_o.start |-> $stable(conv_req_o.ctrl)) else $error("ctrl moved");
  chk_b_answer:
    assert property (wr_go |-> ##2 s_axi_bvalid_o) else $error("no write answer");
  chk_b_hold:
    assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write answer dropped");
  chk_r_answer:
    assert property (rd_go |=> s_axi_rvalid_o) else $error("no read answer");
  chk_r_hold:
    assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data moved");
  chk_ro_write:
    assert property (wr_go && (s_axi_awaddr_i == ADDR_STATUS || s_axi_awaddr_i == ADDR_OPTION ||
      s_axi_awaddr_i == ADDR_RES_HIGH) |-> ##2 s_axi_bresp_o == RESP_SLVERR) else $error("ro write ok");
  chk_option_bit:
    assert property (rd_go && ra == ADDR_OPTION && !$past(reset_i) |=>
      s_axi_rdata_o == {31'h0, $past(option_fitted_i, 2)}) else $error("option bit wrong");
  chk_result_sign:
    assert property (rd_go && ra == ADDR_RES_LOW |=> s_axi_rdata_o[31:16] == 16'h0000 &&
      (s_axi_rdata_o[15:12] == 4'h0 || s_axi_rdata_o[15:12] == {4{s_axi_rdata_o[11]}}))
    else $error("result extension wrong");
  chk_high_byte:
    assert property (rd_go && ra == ADDR_RES_HIGH |=> s_axi_rdata_o[31:8] == 24'h000000)
    else $error("high byte wide");
  cov_start: cover property (conv_req_o.start && conv_req_o.ctrl.bipolar);
  cov_option: cover property (rd_go && ra == ADDR_OPTION);
  cov_refused: cover property (s_axi_bvalid_o && s_axi_bresp_o == RESP_SLVERR);
endmodule
bind mradc_access mradc_access_monitor mon_u (.clock_i(clock_i), .reset_i(reset_i),
  .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .conv_req_o(conv_req_o), .option_fitted_i(option_fitted_i));

// File: verification/tb_mradc_access.sv
// self-checking bench for the multirange converter access block
`timescale 1ns/1ps
module tb_mradc_access;
  import mradc_pkg::*;
  logic clock_i = 0, reset_i = 1, fitted = 1;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic [3:0] wstrb = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  mradc_conv_req_t req;
  mradc_conv_rsp_t rsp;
  logic [9:0] delay = 1;
  logic [11:0] sample = 0;
  logic [7:0] mctrl, starts;
  int miscompares = 0, compares = 0, cyc = 0;
  always #12.5 clock_i = ~clock_i;
  always @(posedge clock_i) cyc <= cyc + 1;
  mradc_access dut_u (.clock_i(clock_i), .reset_i(reset_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .conv_req_o(req), .conv_rsp_i(rsp), .option_fitted_i(fitted));
  mradc_conv_model conv_u (.clock_i(clock_i), .reset_i(reset_i), .req_i(req), .rsp_o(rsp),
    .delay_i(delay), .sample_i(sample), .ctrl_o(mctrl), .starts_o(starts));
  task automatic wrap_up;
    if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // every wait counts its steps; running out ends the run
  task automatic tick(inout int n);
    n++;
    if (n > 2000) begin
      chk("wait bound", 0, 1);
      wrap_up();
    end
  endtask
  // readies sampled at the falling edge equal what the next rising edge sees
  task automatic wr(input logic [31:0] a, d, input logic [3:0] s, output logic [1:0] r);
    logic ta, tw, tk;
    int n;
    n = 0;
    tk = 0;
    awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!tk) begin
      @(negedge clock_i);
      ta = awvalid && awready; tw = wvalid && wready; tk = bvalid; r = bresp;
      @(posedge clock_i);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      if (tk) bready <= 0;
      tick(n);
    end
    @(posedge clock_i);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tk;
    int n;
    n = 0;
    tk = 0;
    araddr <= a; arvalid <= 1; rready <= 1;
    while (!tk) begin
      @(negedge clock_i);
      ta = arvalid && arready; tk = rvalid; d = rdata; r = rresp;
      @(posedge clock_i);
      if (ta) arvalid <= 0;
      if (tk) rready <= 0;
      tick(n);
    end
    @(posedge clock_i);
  endtask
  task automatic wait_idle(output logic [31:0] st);
    logic [1:0] r;
    int n;
    n = 0;
    do begin rd(ADDR_STATUS, st, r); tick(n); end while (st[STAT_BUSY_BIT] !== 1'b0);
  endtask
  task automatic t_idle;
    logic [31:0] d;
    logic [1:0] r;
    rd(ADDR_RES_LOW, d, r); chk("reset result", d, 32'h0);
    rd(ADDR_OPTION, d, r); chk("fitted", d, 32'h1);
    fitted <= 0;
    repeat (2) @(posedge clock_i);
    rd(ADDR_OPTION, d, r); chk("absent", d, 32'h0);
    fitted <= 1;
    rd(ADDR_STATUS, d, r); chk("idle busy", d[7], 1'b0);
  endtask
  // one conversion, then the result read as word and as high byte
  task automatic t_convert(input logic [7:0] c, input logic [11:0] s, input logic [9:0] dl);
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] e;
    logic [7:0] n0;
    e = c[3] ? {{4{s[11]}}, s} : {4'h0, s};
    n0 = starts;
    sample <= s; delay <= dl;
    @(posedge clock_i);
    wr(ADDR_CONTROL, {24'h0, c}, 4'h1, r); chk("start resp", r, RESP_OKAY);
    chk("chip ctrl", mctrl, c); chk("starts", starts, n0 + 8'h01);
    rd(ADDR_STATUS, d, r);
    if (dl > 20) chk("busy", d[7], 1'b1);
    wait_idle(d); chk("no timeout", d[6], 1'b0);
    rd(ADDR_RES_LOW, d, r); chk("word", d, {16'h0, e});
    rd(ADDR_RES_HIGH, d, r); chk("high", d, {24'h0, e[15:8]});
  endtask
  task automatic t_busy;
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] n0;
    n0 = starts;
    delay <= 10'd300;
    @(posedge clock_i);
    wr(ADDR_CONTROL, 32'h46, 4'h1, r);
    wr(ADDR_CONTROL, 32'h51, 4'h1, r); chk("busy write", r, RESP_OKAY);
    chk("one start", starts, n0 + 8'h01); chk("ctrl kept", mctrl, 8'h46);
    wait_idle(d);
    wr(ADDR_CONTROL, 32'h52, 4'h0, r); chk("no strobe", starts, n0 + 8'h01);
  endtask
  // silent chip: busy must still clear within 500 cycles of the start write
  task automatic t_timeout;
    logic [31:0] d, old;
    logic [1:0] r;
    int c0;
    rd(ADDR_RES_LOW, old, r);
    delay <= 10'd0;
    @(posedge clock_i);
    c0 = cyc;
    wr(ADDR_CONTROL, 32'h43, 4'h1, r);
    wait_idle(d); chk("bounded", 32'(cyc - c0 < 500), 1);
    chk("timeout flag", d[6], 1'b1);
    rd(ADDR_RES_LOW, d, r); chk("result kept", d, old);
  endtask
  task automatic t_refused;
    logic [31:0] d;
    logic [1:0] r;
    logic [31:0] bad [4];
    bad = '{ADDR_STATUS, ADDR_RES_HIGH, ADDR_OPTION, 32'h0000_0010};
    foreach (bad[i]) begin
      wr(bad[i], 32'h5A, 4'hF, r); chk("ro write", r, RESP_SLVERR);
    end
    rd(32'h0000_0010, d, r); chk("gap data", d, 0); chk("gap resp", r, RESP_SLVERR);
  endtask
  initial begin
    repeat (16) @(posedge clock_i);
    reset_i <= 0;
    @(posedge clock_i);
    t_idle();
    for (int i = 0; i < 8; i++)
      t_convert(8'h40 | 8'(i) | 8'((i & 3) << 3), 12'(12'h8F1 + i * 12'h31D), 10'(i * 9 + 1));
    t_busy();
    t_timeout();
    t_convert(8'h5F, 12'h800, 10'd470);
    t_refused();
    wrap_up();
  end
endmodule
